// File: bench/sensor_serial_register_access_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

// ==========================================================
// bench for the register access core
module sensor_serial_register_access_tb
	import ssra_pkg::*;
;
	localparam logic [7:0] ID = 8'hA5; // arbitrary identity value
	logic        clk = 1'b0;
	logic        rst_n, boot_done, os_done, mode3, cs_n, sclk, mosi, scl_low, sda_low;
	logic        din_o, din_oe, serial_out_line, sdo_oe, scl_oe, sda_oe, boot_req;
	logic [7:0]  cause, status, uv, ctrl1, ctrl2, int_pin, int_cfg, ths;
	logic [7:0]  m [64];
	logic [31:0] seed = 32'h0001562B;
	logic [31:0] q;
	logic [8:0]  r;
	int          checks = 0, mismatches = 0, k;
	// open-drain and shared lines; a released line shows the inverse
	wire logic   scl = ~(scl_low | scl_oe);
	wire logic   sda = ~(sda_low | sda_oe);
	wire logic   din = din_oe ? din_o : mosi;
	wire logic   rx = mode3 ? din : (sdo_oe ? serial_out_line : ~serial_out_line);

	always #4 clk = ~clk;

	ssra_core #(.IDENTITY(ID)) u_dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_scl(scl), .o_scl_oe(scl_oe),
		.i_sda(sda), .o_sda_oe(sda_oe), .i_cs_n(cs_n), .i_serial_port_clock(sclk), .i_serial_in_line(din),
		.o_serial_in_line(din_o), .o_serial_in_line_oe(din_oe), .o_serial_out_line(serial_out_line),
		.o_serial_out_line_oe(sdo_oe), .i_int_cause(cause), .i_status(status), .i_uv_index(uv),
		.i_boot_done(boot_done), .i_one_shot_done(os_done), .o_ctrl1(ctrl1), .o_ctrl2(ctrl2),
		.o_int_pin(int_pin), .o_int_cfg(int_cfg), .o_uv_threshold(ths), .o_boot_req(boot_req));
	ssra_host u_host (.i_sys_clk(clk), .i_scl(scl), .i_sda(sda), .i_rx(rx), .o_cs_n(cs_n),
		.o_sclk(sclk), .o_mosi(mosi), .o_scl_low(scl_low), .o_sda_low(sda_low));

	// ==========================================================
	// reference model
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	function automatic void mw(input logic [5:0] a, input logic [7:0] d);
		case (a)
			6'h20: m[a] = d & SSRA_MSK_CTRL1;
			6'h21: m[a] = d & SSRA_MSK_CTRL2;
			6'h22: m[a] = d & SSRA_MSK_INT_PIN;
			6'h23: m[a] = d & SSRA_MSK_INT_CFG;
			6'h25: m[a] = d;
			default: ;
		endcase
	endfunction : mw

	function automatic logic [7:0] mr(input logic [5:0] a);
		case (a)
			6'h0F: return ID;
			6'h24: return cause & SSRA_MSK_INT_CAUSE;
			6'h27: return status;
			6'h28: return uv;
			default: return m[a];
		endcase
	endfunction : mr

	// ==========================================================
	// shared steps
	task automatic chkregs();
		repeat (4) @(posedge clk);
		`CHK({ctrl1, ctrl2, int_pin, int_cfg, ths}, {m[32], m[33], m[34], m[35], m[37]})
	endtask : chkregs

	task automatic spiw(input logic inc, input logic [5:0] a, input int n, input logic [31:0] d);
		u_host.spi(1'b0, inc, a, n, d, q);
		for (k = 0; k < n; k++) mw(inc ? 6'(a + k) : a, d[31 - 8 * k -: 8]);
		chkregs();
	endtask : spiw

	task automatic spir(input logic inc, input logic [5:0] a, input int n);
		u_host.spi(1'b1, inc, a, n, 32'h00000000, q);
		for (k = 0; k < n; k++) `CHK(q[8 * (n - 1 - k) +: 8], mr(inc ? 6'(a + k) : a))
	endtask : spir

	task automatic i2cb(input logic [7:0] b, input logic ex);
		u_host.byte8(b, 1'b1, r);
		`CHK(r[0], ex)
	endtask : i2cb

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// watchdog: the sequence needs about 6.5k clocks
	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end

	// ==========================================================
	// main sequence; stays inside the register map
	initial begin
		rst_n = 1'b0;
		boot_done = 1'b0;
		os_done = 1'b0;
		mode3 = 1'b0;
		{cause, status, uv} = 24'h000000;
		for (k = 0; k < 64; k++) m[k] = 8'h00;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		chkregs();
		`CHK(boot_req, 1'b1)
		boot_done <= 1'b1;
		@(posedge clk);
		boot_done <= 1'b0;
		cause <= 8'(xs());
		status <= 8'(xs());
		uv <= 8'(xs());
		repeat (2) @(posedge clk);
		`CHK(boot_req, 1'b0)
		spiw(1'b0, 6'h20, 1, 32'hFF000000);
		spiw(1'b1, 6'h22, 3, xs());
		spir(1'b0, 6'h0F, 2);
		spir(1'b1, 6'h23, 3);
		spiw(1'b0, 6'h21, 1, 32'h08000000);
		mode3 = 1'b1;
		spir(1'b1, 6'h27, 2);
		spiw(1'b0, 6'h21, 1, 32'h10000000);
		mode3 = 1'b0;
		u_host.start();
		i2cb(8'h8E, 1'b1);
		u_host.stop();
		// one-shot bit self-clears when the measurement side reports done
		spiw(1'b0, 6'h21, 1, 32'h01000000);
		os_done <= 1'b1;
		@(posedge clk);
		os_done <= 1'b0;
		m[33] = 8'h00;
		chkregs();
		spiw(1'b0, 6'h21, 1, 32'h00000000);
		q = xs();
		u_host.start();
		i2cb(8'h8E, 1'b0);
		i2cb(8'hA2, 1'b0);
		i2cb(q[7:0], 1'b0);
		i2cb(q[15:8], 1'b0);
		u_host.stop();
		mw(6'h22, q[7:0]);
		mw(6'h23, q[15:8]);
		chkregs();
		u_host.start();
		i2cb(8'h90, 1'b1);
		u_host.stop();
		u_host.start();
		i2cb(8'h8E, 1'b0);
		i2cb(8'hA3, 1'b0);
		u_host.start();
		i2cb(8'h8F, 1'b0);
		for (k = 0; k < 3; k++) begin
			u_host.byte8(8'hFF, k == 2, r);
			`CHK(r[8:1], mr(6'(6'h23 + k)))
		end
		u_host.stop();
		report_and_stop();
	end
endmodule : sensor_serial_register_access_tb

`default_nettype wire

// File: bench/ssra_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// port checks for the register access core
module ssra_asserts
	import ssra_pkg::*;
(
	input wire logic       i_sys_clk,
	input wire logic       i_arst_n,
	input wire logic       i_scl,
	input wire logic       o_scl_oe,
	input wire logic       o_sda_oe,
	input wire logic       i_cs_n,
	input wire logic       i_serial_port_clock,
	input wire logic       o_serial_in_line_oe,
	input wire logic       o_serial_out_line,
	input wire logic       o_serial_out_line_oe,
	input wire logic       i_boot_done,
	input wire logic [7:0] o_ctrl1,
	input wire logic [7:0] o_ctrl2,
	input wire logic [7:0] o_int_pin,
	input wire logic [7:0] o_int_cfg,
	input wire logic       o_boot_req
);
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_arst_n);

	// ==========================================================
	// link pins
	a_scl_released: assert property (!o_scl_oe) else $error("scl held low");
	a_oe_cs_low: assert property ($rose(o_serial_out_line_oe) || $rose(o_serial_in_line_oe) |-> !i_cs_n)
		else $error("drive began with select high");
	a_oe_release: assert property ($rose(i_cs_n) |-> ##[1:6] !(o_serial_out_line_oe || o_serial_in_line_oe))
		else $error("data line not released");
	a_in_oe_mode: assert property (o_serial_in_line_oe |-> o_ctrl2[SSRA_BIT_THREE_WIRE_SELECT])
		else $error("input line driven in 4-wire mode");
	a_out_oe_mode: assert property (o_serial_out_line_oe |-> !o_ctrl2[SSRA_BIT_THREE_WIRE_SELECT])
		else $error("output line driven in 3-wire mode");
	// the synchroniser delays the clock view, so look two cycles back
	a_out_on_fall: assert property (o_serial_out_line_oe && $changed(o_serial_out_line)
		|-> !$past(i_serial_port_clock, 2)) else $error("read bit moved on rising clock");
	a_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("data drive changed with clock high");

	// ==========================================================
	// boot and register contents
	a_boot_start: assert property (!$past(i_arst_n) |=> o_boot_req) else $error("no boot after reset");
	a_boot_clear: assert property ($fell(o_boot_req) |-> $past(i_boot_done))
		else $error("boot request dropped early");
	a_reserved_zero: assert property ((o_ctrl1 & ~SSRA_MSK_CTRL1) == 8'h00
		&& (o_ctrl2 & ~SSRA_MSK_CTRL2) == 8'h00 && (o_int_pin & ~SSRA_MSK_INT_PIN) == 8'h00
		&& (o_int_cfg & ~SSRA_MSK_INT_CFG) == 8'h00) else $error("reserved bit set");
endmodule : ssra_asserts

bind ssra_core ssra_asserts u_chk (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_scl(i_scl),
	.o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .i_cs_n(i_cs_n), .i_serial_port_clock(i_serial_port_clock),
	.o_serial_in_line_oe(o_serial_in_line_oe), .o_serial_out_line(o_serial_out_line),
	.o_serial_out_line_oe(o_serial_out_line_oe), .i_boot_done(i_boot_done), .o_ctrl1(o_ctrl1),
	.o_ctrl2(o_ctrl2), .o_int_pin(o_int_pin), .o_int_cfg(o_int_cfg), .o_boot_req(o_boot_req));

`default_nettype wire

// File: bench/ssra_host.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host master for both links; half link period is ten clocks
module ssra_host (
	input  wire logic i_sys_clk,
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_rx,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_mosi,
	output logic      o_scl_low,
	output logic      o_sda_low
);
	// idle: select high, clock parked high, open-drain lines released
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_mosi = 1'b1;
		o_scl_low = 1'b0;
		o_sda_low = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask : wt

	// bytes leave wd from the top; read bytes gather at the bottom of q
	task automatic spi(input logic rd, input logic inc, input logic [5:0] idx, input int n,
		input logic [31:0] wd, output logic [31:0] q);
		logic [39:0] sh;
		int i;
		sh = {rd, inc, idx, wd};
		q = '0;
		wt(1);
		o_cs_n <= 1'b0;
		for (i = 0; i < 8 + 8 * n; i++) begin
			wt(10);
			o_sclk <= 1'b0;
			o_mosi <= (rd && i >= 8) ? ~o_mosi : sh[39-i];
			wt(10);
			if (i >= 8) q = {q[30:0], i_rx};
			o_sclk <= 1'b1;
		end
		wt(10);
		o_cs_n <= 1'b1;
		wt(10);
	endtask : spi

	// start or repeated start
	task automatic start();
		wt(5);
		o_sda_low <= 1'b0;
		wt(5);
		o_scl_low <= 1'b0;
		wt(10);
		o_sda_low <= 1'b1;
		wt(10);
		o_scl_low <= 1'b1;
	endtask : start

	task automatic stop();
		wt(5);
		o_sda_low <= 1'b1;
		wt(5);
		o_scl_low <= 1'b0;
		wt(10);
		o_sda_low <= 1'b0;
		wt(10);
	endtask : stop

	// a slow receiver may hold the clock low, so wait for the line
	task automatic bitx(input logic b, output logic v);
		wt(5);
		o_sda_low <= !b;
		wt(5);
		o_scl_low <= 1'b0;
		wt(10);
		while (!i_scl) wt(1);
		v = i_sda;
		o_scl_low <= 1'b1;
	endtask : bitx

	// eight bits msb first then the ack slot; a is the master ack level
	task automatic byte8(input logic [7:0] b, input logic a, output logic [8:0] r);
		logic v;
		int i;
		for (i = 0; i < 9; i++) begin
			bitx(i < 8 ? b[7-i] : a, v);
			r = {r[7:0], v};
		end
	endtask : byte8
endmodule : ssra_host

`default_nettype wire

// File: rtl/ssra_core.sv
`timescale 1ns/1ps
`default_nettype none

module ssra_core
	import ssra_pkg::*;
#(
	parameter logic [7:0] IDENTITY = 8'h5A  // arbitrary identity value
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_scl,
	output logic            o_scl_oe,
	input  wire logic       i_sda,
	output logic            o_sda_oe,
	input  wire logic       i_cs_n,
	input  wire logic       i_serial_port_clock,
	input  wire logic       i_serial_in_line,
	output logic            o_serial_in_line,
	output logic            o_serial_in_line_oe,
	output logic            o_serial_out_line,
	output logic            o_serial_out_line_oe,
	input  wire logic [7:0] i_int_cause,
	input  wire logic [7:0] i_status,
	input  wire logic [7:0] i_uv_index,
	input  wire logic       i_boot_done,
	input  wire logic       i_one_shot_done,
	output logic      [7:0] o_ctrl1,
	output logic      [7:0] o_ctrl2,
	output logic      [7:0] o_int_pin,
	output logic      [7:0] o_int_cfg,
	output logic      [7:0] o_uv_threshold,
	output logic            o_boot_req
);

	// ==========================================================
	// pin synchronisers
	logic scl_s, sda_s, cs_n_s, spc_s, sdi_s;
	logic scl_d_r, sda_d_r, spc_d_r;

	ssra_sync #(.WIDTH(5), .RST_VAL(5'h1F)) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_arst_n  (i_arst_n),
		.i_async   ({i_scl, i_sda, i_cs_n, i_serial_port_clock, i_serial_in_line}),
		.o_sync    ({scl_s, sda_s, cs_n_s, spc_s, sdi_s})
	);

	// delayed copies for edge detection
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			spc_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			spc_d_r <= spc_s;
		end
	end

	logic spc_rise, spc_fall, scl_rise, scl_fall, i2c_start, i2c_stop;
	assign spc_rise  = spc_s & ~spc_d_r;
	assign spc_fall  = ~spc_s & spc_d_r;
	assign scl_rise  = scl_s & ~scl_d_r;
	assign scl_fall  = ~scl_s & scl_d_r;
	assign i2c_start = scl_s & scl_d_r & ~sda_s & sda_d_r;
	assign i2c_stop  = scl_s & scl_d_r & sda_s & ~sda_d_r;

	// ==========================================================
	// register file
	logic [7:0] ctrl1_r, ctrl2_r, int_pin_r, int_cfg_r, ths_r;
	logic [7:0] ctrl1_nxt, ctrl2_nxt, int_pin_nxt, int_cfg_nxt, ths_nxt;
	logic       boot_pend_r, boot_pend_nxt;
	ssra_wr_s   wr, spi_wr, i2c_wr;

	// read decode shared by both links; unmapped and reserved read zero
	function automatic logic [7:0] rd_byte(input logic [6:0] a);
		case (a)
			SSRA_ADR_IDENTITY:  rd_byte = IDENTITY;
			SSRA_ADR_CTRL1:     rd_byte = ctrl1_r;
			SSRA_ADR_CTRL2:     rd_byte = ctrl2_r;
			SSRA_ADR_INT_PIN:   rd_byte = int_pin_r;
			SSRA_ADR_INT_CFG:   rd_byte = int_cfg_r;
			SSRA_ADR_INT_CAUSE: rd_byte = i_int_cause & SSRA_MSK_INT_CAUSE;
			SSRA_ADR_UV_THS:    rd_byte = ths_r;
			SSRA_ADR_STATUS:    rd_byte = i_status;
			SSRA_ADR_UV_OUT:    rd_byte = i_uv_index;
			default:            rd_byte = 8'h00;
		endcase
	endfunction : rd_byte

	// the links never overlap in practice; spi takes the port if both write
	assign wr = spi_wr.en ? spi_wr : i2c_wr;

	// writes land in writable bits only; read-only addresses drop the write
	always_comb begin
		ctrl1_nxt     = ctrl1_r;
		ctrl2_nxt     = ctrl2_r;
		int_pin_nxt   = int_pin_r;
		int_cfg_nxt   = int_cfg_r;
		ths_nxt       = ths_r;
		boot_pend_nxt = boot_pend_r & ~i_boot_done;
		// self-clearing bits drop when the measurement side reports done
		if (i_boot_done)
			ctrl2_nxt[SSRA_BIT_BOOT] = 1'b0;
		if (i_one_shot_done)
			ctrl2_nxt[SSRA_BIT_ONE_SHOT] = 1'b0;
		if (wr.en) begin
			case (wr.addr)
				SSRA_ADR_CTRL1:   ctrl1_nxt   = wr.data & SSRA_MSK_CTRL1;
				SSRA_ADR_CTRL2:   ctrl2_nxt   = wr.data & SSRA_MSK_CTRL2; // write wins over self-clear
				SSRA_ADR_INT_PIN: int_pin_nxt = wr.data & SSRA_MSK_INT_PIN;
				SSRA_ADR_INT_CFG: int_cfg_nxt = wr.data & SSRA_MSK_INT_CFG;
				SSRA_ADR_UV_THS:  ths_nxt     = wr.data;
				default: ;
			endcase
		end
	end

	// boot pending from reset so calibration reloads at power-up
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl1_r     <= SSRA_RST_REG;
			ctrl2_r     <= SSRA_RST_REG;
			int_pin_r   <= SSRA_RST_REG;
			int_cfg_r   <= SSRA_RST_REG;
			ths_r       <= SSRA_RST_REG;
			boot_pend_r <= 1'b1;
			o_boot_req  <= 1'b0;
		end else begin
			ctrl1_r     <= ctrl1_nxt;
			ctrl2_r     <= ctrl2_nxt;
			int_pin_r   <= int_pin_nxt;
			int_cfg_r   <= int_cfg_nxt;
			ths_r       <= ths_nxt;
			boot_pend_r <= boot_pend_nxt;
			o_boot_req  <= boot_pend_nxt | ctrl2_nxt[SSRA_BIT_BOOT];
		end
	end

	assign o_ctrl1        = ctrl1_r;
	assign o_ctrl2        = ctrl2_r;
	assign o_int_pin      = int_pin_r;
	assign o_int_cfg      = int_cfg_r;
	assign o_uv_threshold = ths_r;

	// ==========================================================
	// spi slave
	logic       sp_cmd_r, sp_rw_r, sp_inc_r, sp_drv_r, sp_out_r;
	logic       sp_cmd_nxt, sp_rw_nxt, sp_inc_nxt, sp_drv_nxt, sp_out_nxt;
	logic [2:0] sp_cnt_r, sp_cnt_nxt;
	logic [5:0] sp_addr_r, sp_addr_nxt;
	logic [7:0] sp_sh_r, sp_sh_nxt, sp_tx_r, sp_tx_nxt;
	logic [7:0] sp_sh_in, sp_tx_ld;

	assign sp_sh_in = {sp_sh_r[6:0], sdi_s};
	assign sp_tx_ld = rd_byte({1'b0, sp_addr_r});

	// command byte, then data blocks of eight rising edges each
	always_comb begin
		sp_cmd_nxt  = sp_cmd_r;
		sp_rw_nxt   = sp_rw_r;
		sp_inc_nxt  = sp_inc_r;
		sp_drv_nxt  = sp_drv_r;
		sp_out_nxt  = sp_out_r;
		sp_cnt_nxt  = sp_cnt_r;
		sp_addr_nxt = sp_addr_r;
		sp_sh_nxt   = sp_sh_r;
		sp_tx_nxt   = sp_tx_r;
		spi_wr      = '0;
		if (cs_n_s) begin
			// idle: line released once the synchronised select reads high
			sp_cmd_nxt = 1'b0;
			sp_cnt_nxt = 3'h0;
			sp_drv_nxt = 1'b0;
		end else if (spc_rise) begin
			sp_sh_nxt  = sp_sh_in;
			sp_cnt_nxt = sp_cnt_r + 3'h1;
			if (sp_cnt_r == 3'h7) begin
				if (!sp_cmd_r) begin
					sp_cmd_nxt  = 1'b1;
					sp_rw_nxt   = sp_sh_in[7];
					sp_inc_nxt  = sp_sh_in[6];
					sp_addr_nxt = sp_sh_in[5:0];
				end else begin
					spi_wr.en   = ~sp_rw_r;
					spi_wr.addr = {1'b0, sp_addr_r};
					spi_wr.data = sp_sh_in;
					sp_addr_nxt = sp_addr_r + {5'h00, sp_inc_r};
				end
			end
		end else if (spc_fall && sp_cmd_r && sp_rw_r) begin
			// first fall of a block loads the byte, later falls shift it out
			if (sp_cnt_r == 3'h0) begin
				sp_out_nxt = sp_tx_ld[7];
				sp_tx_nxt  = {sp_tx_ld[6:0], 1'b0};
				sp_drv_nxt = 1'b1;
			end else begin
				sp_out_nxt = sp_tx_r[7];
				sp_tx_nxt  = {sp_tx_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sp_cmd_r  <= 1'b0;
			sp_rw_r   <= 1'b0;
			sp_inc_r  <= 1'b0;
			sp_drv_r  <= 1'b0;
			sp_out_r  <= 1'b0;
			sp_cnt_r  <= 3'h0;
			sp_addr_r <= 6'h00;
			sp_sh_r   <= 8'h00;
			sp_tx_r   <= 8'h00;
			o_serial_out_line    <= 1'b0;
			o_serial_out_line_oe <= 1'b0;
			o_serial_in_line     <= 1'b0;
			o_serial_in_line_oe  <= 1'b0;
		end else begin
			sp_cmd_r  <= sp_cmd_nxt;
			sp_rw_r   <= sp_rw_nxt;
			sp_inc_r  <= sp_inc_nxt;
			sp_drv_r  <= sp_drv_nxt;
			sp_out_r  <= sp_out_nxt;
			sp_cnt_r  <= sp_cnt_nxt;
			sp_addr_r <= sp_addr_nxt;
			sp_sh_r   <= sp_sh_nxt;
			sp_tx_r   <= sp_tx_nxt;
			// mode bit steers read data to the output or the shared input line
			o_serial_out_line    <= sp_out_nxt;
			o_serial_out_line_oe <= sp_drv_nxt & ~ctrl2_r[SSRA_BIT_THREE_WIRE_SELECT];
			o_serial_in_line     <= sp_out_nxt;
			o_serial_in_line_oe  <= sp_drv_nxt & ctrl2_r[SSRA_BIT_THREE_WIRE_SELECT];
		end
	end

	// ==========================================================
	// i2c slave
	ssra_i2c_state_e i_st_r, i_st_nxt;
	logic [3:0] i_bc_r, i_bc_nxt;
	logic [7:0] i_sh_r, i_sh_nxt, i_ld;
	logic [6:0] i_ptr_r, i_ptr_nxt;
	logic       i_ack_r, i_ack_nxt, i_rw_r, i_rw_nxt, i_inc_r, i_inc_nxt;
	logic       i_mack_r, i_mack_nxt, i_oe_nxt;

	assign i_ld = rd_byte(i_ptr_r);

	// bc counts data bits; ack_r marks the ninth clock of a byte
	always_comb begin
		i_st_nxt   = i_st_r;
		i_bc_nxt   = i_bc_r;
		i_sh_nxt   = i_sh_r;
		i_ptr_nxt  = i_ptr_r;
		i_ack_nxt  = i_ack_r;
		i_rw_nxt   = i_rw_r;
		i_inc_nxt  = i_inc_r;
		i_mack_nxt = i_mack_r;
		i_oe_nxt   = o_sda_oe;
		i2c_wr     = '0;
		if (ctrl2_r[SSRA_BIT_TWO_WIRE_DISABLE] || i2c_stop) begin
			i_st_nxt = I2C_IDLE;
			i_oe_nxt = 1'b0;
			i_ack_nxt = 1'b0;
		end else if (i2c_start) begin
			// repeated start keeps the pointer for the read phase
			i_st_nxt  = I2C_ADDR;
			i_bc_nxt  = 4'h0;
			i_ack_nxt = 1'b0;
			i_oe_nxt  = 1'b0;
		end else if (i_st_r == I2C_IDLE || i_st_r == I2C_WAIT) begin
			i_oe_nxt = 1'b0;
		end else if (scl_rise) begin
			if (i_bc_r < SSRA_BYTE_BITS) begin
				if (i_st_r != I2C_RD)
					i_sh_nxt = {i_sh_r[6:0], sda_s};
				i_bc_nxt = i_bc_r + 4'h1;
			end else if (i_ack_r && i_st_r == I2C_RD)
				i_mack_nxt = ~sda_s;
		end else if (scl_fall) begin
			if (i_bc_r < SSRA_BYTE_BITS) begin
				if (i_st_r == I2C_RD && i_bc_r != 4'h0) begin
					i_oe_nxt = ~i_sh_r[6];
					i_sh_nxt = {i_sh_r[6:0], 1'b0};
				end
			end else if (!i_ack_r) begin
				i_ack_nxt = 1'b1;
				case (i_st_r)
					I2C_ADDR: begin
						if (i_sh_r[7:1] == SSRA_I2C_SLAVE_ADDR) begin
							i_oe_nxt = 1'b1;
							i_rw_nxt = i_sh_r[0];
						end else begin
							i_oe_nxt = 1'b0;
							i_st_nxt = I2C_WAIT;
						end
					end
					I2C_SUB: begin
						i_oe_nxt  = 1'b1;
						i_ptr_nxt = i_sh_r[6:0];
						i_inc_nxt = i_sh_r[7];
					end
					I2C_WR: begin
						i_oe_nxt    = 1'b1;
						i2c_wr.en   = 1'b1;
						i2c_wr.addr = i_ptr_r;
						i2c_wr.data = i_sh_r;
					end
					default: begin
						// master answers the read byte
						i_oe_nxt  = 1'b0;
						i_ptr_nxt = i_ptr_r + {6'h00, i_inc_r};
					end
				endcase
			end else begin
				i_ack_nxt = 1'b0;
				i_bc_nxt  = 4'h0;
				i_oe_nxt  = 1'b0;
				case (i_st_r)
					I2C_ADDR: begin
						if (i_rw_r) begin
							i_st_nxt = I2C_RD;
							i_sh_nxt = i_ld;
							i_oe_nxt = ~i_ld[7];
						end else
							i_st_nxt = I2C_SUB;
					end
					I2C_SUB: i_st_nxt = I2C_WR;
					I2C_WR:  i_ptr_nxt = i_ptr_r + {6'h00, i_inc_r};
					default: begin
						if (i_mack_r) begin
							i_sh_nxt = i_ld;
							i_oe_nxt = ~i_ld[7];
						end else
							i_st_nxt = I2C_WAIT;
					end
				endcase
			end
		end
	end

	// no clock stretching: register access completes within one cycle
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			i_st_r   <= I2C_IDLE;
			i_bc_r   <= 4'h0;
			i_sh_r   <= 8'h00;
			i_ptr_r  <= 7'h00;
			i_ack_r  <= 1'b0;
			i_rw_r   <= 1'b0;
			i_inc_r  <= 1'b0;
			i_mack_r <= 1'b0;
			o_sda_oe <= 1'b0;
			o_scl_oe <= 1'b0;
		end else begin
			i_st_r   <= i_st_nxt;
			i_bc_r   <= i_bc_nxt;
			i_sh_r   <= i_sh_nxt;
			i_ptr_r  <= i_ptr_nxt;
			i_ack_r  <= i_ack_nxt;
			i_rw_r   <= i_rw_nxt;
			i_inc_r  <= i_inc_nxt;
			i_mack_r <= i_mack_nxt;
			o_sda_oe <= i_oe_nxt;
			o_scl_oe <= 1'b0;
		end
	end

endmodule : ssra_core

`default_nettype wire

// File: rtl/ssra_pkg.sv
package ssra_pkg;

	// ==========================================================
	// register indices (7-bit register address space)
	localparam logic [6:0] SSRA_ADR_IDENTITY  = 7'h0F;
	localparam logic [6:0] SSRA_ADR_CTRL1     = 7'h20;
	localparam logic [6:0] SSRA_ADR_CTRL2     = 7'h21;
	localparam logic [6:0] SSRA_ADR_INT_PIN   = 7'h22;
	localparam logic [6:0] SSRA_ADR_INT_CFG   = 7'h23;
	localparam logic [6:0] SSRA_ADR_INT_CAUSE = 7'h24;
	localparam logic [6:0] SSRA_ADR_UV_THS    = 7'h25;
	localparam logic [6:0] SSRA_ADR_STATUS    = 7'h27;
	localparam logic [6:0] SSRA_ADR_UV_OUT    = 7'h28;

	// ==========================================================
	// reset values and implemented-bit masks
	localparam logic [7:0] SSRA_RST_REG       = 8'h00;
	localparam logic [7:0] SSRA_MSK_CTRL1     = 8'h03;
	localparam logic [7:0] SSRA_MSK_CTRL2     = 8'h99;
	localparam logic [7:0] SSRA_MSK_INT_PIN   = 8'hC3;
	localparam logic [7:0] SSRA_MSK_INT_CFG   = 8'h0F;
	localparam logic [7:0] SSRA_MSK_INT_CAUSE = 8'h07;

	// ==========================================================
	// field positions in control_second
	localparam int SSRA_BIT_BOOT      = 7;
	localparam int SSRA_BIT_TWO_WIRE_DISABLE = 4;
	localparam int SSRA_BIT_THREE_WIRE_SELECT = 3;
	localparam int SSRA_BIT_ONE_SHOT  = 0;

	// ==========================================================
	// link constants
	localparam logic [6:0] SSRA_I2C_SLAVE_ADDR = 7'h47;
	localparam logic [3:0] SSRA_BYTE_BITS      = 4'h8;

	// ==========================================================
	// types
	typedef struct packed {
		logic       en;
		logic [6:0] addr;
		logic [7:0] data;
	} ssra_wr_s;

	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_SUB,
		I2C_WR,
		I2C_RD,
		I2C_WAIT
	} ssra_i2c_state_e;

endpackage : ssra_pkg

// File: rtl/ssra_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// two-flop synchroniser for pins from the link side
module ssra_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_arst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_r;

	// first stage only feeds the second stage
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r <= RST_VAL;
			o_sync <= RST_VAL;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end

endmodule : ssra_sync

`default_nettype wire
